// ### core/loop_controller.sv
// Purpose: loop controller end, driven by software over APB
// Assumes: software orders messages in the legal addressing sequence
// Notes: zero-wait APB slave; one link message per MESSAGE write
module loop_controller (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  loop_link_if.controller LINK
);
  // ==========================================================
  // state
  logic [7:0] last_byte;
  logic [7:0] byte_count;
  logic [loop_pkg::IRQ_WIDTH-1:0] irq_status;
  logic [loop_pkg::IRQ_WIDTH-1:0] irq_mask;

  // ==========================================================
  // bus decode
  wire logic setup = PSEL && !PENABLE;
  wire logic hit_msg = PADDR == loop_pkg::OFS_MESSAGE;
  wire logic hit_rx = PADDR == loop_pkg::OFS_RX;
  wire logic hit_sts = PADDR == loop_pkg::OFS_IRQ_STATUS;
  wire logic hit_mask = PADDR == loop_pkg::OFS_IRQ_MASK;
  wire logic mapped = hit_msg || hit_rx || hit_sts || hit_mask;
  wire logic wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  wire logic [31:0] rd_mux = hit_rx ? {16'h0000, byte_count, last_byte}
      : hit_sts ? {30'h0, irq_status}
      : hit_mask ? {30'h0, irq_mask} : 32'h00000000;
  wire logic got_byte = LINK.rsp_valid && !LINK.rsp_eot;
  wire logic got_eot = LINK.rsp_valid && LINK.rsp_eot;
  wire logic [loop_pkg::IRQ_WIDTH-1:0] irq_set = {got_eot, got_byte};
  wire logic [loop_pkg::IRQ_WIDTH-1:0] irq_clr = wr && hit_sts
      ? PWDATA[loop_pkg::IRQ_WIDTH-1:0] : '0;
  // a new event beats a same-cycle clear
  wire logic [loop_pkg::IRQ_WIDTH-1:0] next_status
      = (irq_status & ~irq_clr) | irq_set;
  wire logic [loop_pkg::IRQ_WIDTH-1:0] next_mask = wr && hit_mask
      ? PWDATA[loop_pkg::IRQ_WIDTH-1:0] : irq_mask;

  // ==========================================================
  // APB slave
  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !mapped;
      PRDATA <= setup && !PWRITE ? rd_mux : 32'h00000000;
    end
  end

  // ==========================================================
  // link messages out: software issues them in the legal order
  always_ff @(posedge CLK) begin
    if (RST) begin
      LINK.msg_valid <= 1'b0;
      LINK.msg_kind <= loop_pkg::MSG_DATA;
      LINK.msg_data <= 8'h00;
    end else begin
      LINK.msg_valid <= wr && hit_msg;
      if (wr && hit_msg) begin
        LINK.msg_kind <= loop_pkg::msg_kind_type'(PWDATA[10:8]);
        LINK.msg_data <= PWDATA[7:0];
      end
    end
  end

  // ==========================================================
  // readback capture and interrupt
  always_ff @(posedge CLK) begin
    if (RST) begin
      last_byte <= 8'h00;
      byte_count <= 8'h00;
      irq_status <= '0;
      irq_mask <= '0;
      IRQ <= 1'b0;
    end else begin
      if (got_byte) begin
        last_byte <= LINK.rsp_data;
        byte_count <= byte_count + 8'h01;
      end else if (wr && hit_rx) begin
        byte_count <= 8'h00;
      end
      irq_status <= next_status;
      irq_mask <= next_mask;
      IRQ <= |(next_status & next_mask);
    end
  end
endmodule : loop_controller

// ### core/loop_device.sv
// Purpose: remote-mode instruction interpreter of the loop device
// Assumes: controller keeps the addressing order on the link
// Notes: instructions are at most three characters long
//
// Contract
// - instructions taken only while addressed listener
// - remote enable plus own listen address: remote
// - not-remote-enable returns to local mode
// - unlisten drops listener, stops instruction parsing
// - own talk address: talker, leaves listener
// - semicolon-separated instructions, CR LF ends line
// - frame register holds word length, stop bits
// - control readback arms control register set
// - character readback arms character register set
// - controller makes talker then sends send-data
// - one byte per register, ascending order
// - register nibble in low nibble
// - end-of-transmission OK after last byte
// - controller sends untalk; device leaves talker
// - master register 1100: all plus data error
// - buffer register 0110: two buffer conditions
// - disconnect register 0100: disconnect on DSR false; no instruction writes it here, so it stays 0000
// - master bit 3 gates all buffer enables
//
// The APB interface to the registers was decided locally.
module loop_device #(
  parameter logic [4:0] OWN_ADDR = loop_pkg::OWN_ADDR_DEFAULT
) (
  input wire logic CLK,
  input wire logic RST,
  loop_link_if.device LINK,
  input wire logic TX_EMPTY,
  input wire logic TX_NOT_FULL,
  input wire logic RX_NOT_EMPTY,
  input wire logic RX_FULL,
  input wire logic DATA_ERROR,
  input wire logic DSR,
  output logic REMOTE,
  output logic LISTENER,
  output logic TALKER,
  output logic SYNTAX_ERROR,
  output logic SERVICE_REQUEST,
  output logic AUTODISCONNECT,
  output logic [1:0] WORD_CODE,
  output logic TWO_STOP,
  output logic PARITY_REPORT,
  output logic RECEIVER_PROTOCOL,
  output logic [2:0] HANDSHAKE_IGNORE
);
  // ==========================================================
  // state
  logic [3:0] ctrl [loop_pkg::REG_FILE_SIZE];
  logic [7:0] tok [3];
  logic [1:0] tok_len;
  logic tok_over;
  logic remote_enabled;
  loop_pkg::arm_type armed;
  loop_pkg::arm_type sending;
  loop_pkg::tx_state_type tx_state;
  logic [3:0] idx;

  // ==========================================================
  // message decode
  wire logic own_addr = LINK.msg_data[4:0] == OWN_ADDR;
  wire logic got_ren = LINK.msg_valid && LINK.msg_kind == loop_pkg::MSG_REN;
  wire logic got_nre = LINK.msg_valid && LINK.msg_kind == loop_pkg::MSG_NRE;
  wire logic got_lad = LINK.msg_valid && LINK.msg_kind == loop_pkg::MSG_LAD;
  wire logic got_unl = LINK.msg_valid && LINK.msg_kind == loop_pkg::MSG_UNL;
  wire logic got_tad = LINK.msg_valid && LINK.msg_kind == loop_pkg::MSG_TAD;
  wire logic got_unt = LINK.msg_valid && LINK.msg_kind == loop_pkg::MSG_UNT;
  wire logic got_sda = LINK.msg_valid && LINK.msg_kind == loop_pkg::MSG_SDA;
  wire logic lad_own = got_lad && own_addr;
  wire logic tad_own = got_tad && own_addr;
  wire logic data_take = LINK.msg_valid
      && LINK.msg_kind == loop_pkg::MSG_DATA
      && LISTENER && REMOTE;
  wire logic [7:0] ch = LINK.msg_data;
  wire logic is_sep = ch == loop_pkg::CH_SEMI || ch == loop_pkg::CH_CR;
  wire logic is_lf = ch == loop_pkg::CH_LF;

  // ==========================================================
  // instruction decode on the collected token
  wire logic exec = data_take && is_sep && tok_len != 2'd0;
  wire logic len3 = tok_len == 2'd3 && !tok_over;
  wire logic len2 = tok_len == 2'd2 && !tok_over;
  wire logic [7:0] d3 = tok[2] - loop_pkg::CH_ZERO;
  wire logic [7:0] d2 = tok[1] - loop_pkg::CH_ZERO;
  wire logic t2_dec = tok[2] >= loop_pkg::CH_ZERO && d3 < 8'h0A;
  wire logic t2_hex = tok[2] >= loop_pkg::CH_A && tok[2] <= 8'h46;
  wire logic [7:0] hexv = t2_hex ? tok[2] - loop_pkg::CH_HEX_OFS : d3;
  wire logic is_s = len3 && tok[0] == loop_pkg::CH_S;
  wire logic i_sp = is_s && tok[1] == loop_pkg::CH_P && t2_dec && d3 < 8'h02;
  wire logic i_sr0 = is_s && tok[1] == loop_pkg::CH_R && d3 == 8'h00;
  wire logic i_sr2 = is_s && tok[1] == loop_pkg::CH_R && d3 == 8'h02;
  wire logic i_ss = is_s && tok[1] == loop_pkg::CH_S && t2_dec && d3 < 8'h02;
  wire logic i_sw = is_s && tok[1] == loop_pkg::CH_W && t2_dec && d3 < 8'h04;
  wire logic i_sl0 = is_s && tok[1] == loop_pkg::CH_L && d3 == 8'h00;
  wire logic i_sb = is_s && tok[1] == loop_pkg::CH_B
      && (t2_hex || (t2_dec && d3 != 8'h00));
  wire logic i_se = is_s && tok[1] == loop_pkg::CH_E && t2_dec
      && (d3 < 8'h05 || d3 == 8'h06);
  wire logic i_c0 = len2 && tok[0] == loop_pkg::CH_C && d2 == 8'h00;
  wire logic i_c2 = len2 && tok[0] == loop_pkg::CH_C && d2 == 8'h02;
  wire logic i_p = len2 && tok[0] == loop_pkg::CH_P
      && tok[1] >= loop_pkg::CH_ZERO && d2 < 8'h05;
  wire logic known = i_sp || i_sr0 || i_sr2 || i_ss || i_sw || i_sl0
      || i_sb || i_se || i_c0 || i_c2 || i_p;

  // ==========================================================
  // readback byte
  // character registers load elsewhere, so readback shows reset contents
  wire logic [3:0] rb_nib = sending == loop_pkg::ARM_CHARACTER
      ? loop_pkg::REG_RESET : ctrl[idx];
  wire logic [3:0] rb_last = sending == loop_pkg::ARM_CHARACTER
      ? 4'(loop_pkg::CHAR_COUNT - 1) : 4'(loop_pkg::CTRL_COUNT - 1);
  wire logic srq_any = (ctrl[loop_pkg::REG_BUF_REQ][0] && TX_EMPTY)
      || (ctrl[loop_pkg::REG_BUF_REQ][1] && TX_NOT_FULL)
      || (ctrl[loop_pkg::REG_BUF_REQ][2] && RX_NOT_EMPTY)
      || (ctrl[loop_pkg::REG_BUF_REQ][3] && RX_FULL)
      || (ctrl[loop_pkg::REG_SRQ_MASTER][loop_pkg::SRQ_DATA_ERR_BIT]
          && DATA_ERROR);

  // ==========================================================
  // addressing and mode
  always_ff @(posedge CLK) begin
    if (RST) begin
      remote_enabled <= 1'b0;
      REMOTE <= 1'b0;
      LISTENER <= 1'b0;
      TALKER <= 1'b0;
    end else begin
      if (got_ren) remote_enabled <= 1'b1;
      if (got_nre) begin
        remote_enabled <= 1'b0;
        REMOTE <= 1'b0;
      end else if (lad_own && remote_enabled) begin
        REMOTE <= 1'b1;
      end
      if (lad_own) LISTENER <= 1'b1;
      else if (got_unl || tad_own) LISTENER <= 1'b0;
      if (tad_own) TALKER <= 1'b1;
      else if (got_unt || got_tad) TALKER <= 1'b0;
    end
  end

  // ==========================================================
  // token collection and instruction execution
  always_ff @(posedge CLK) begin
    if (RST) begin
      tok_len <= 2'd0;
      tok_over <= 1'b0;
      SYNTAX_ERROR <= 1'b0;
      armed <= loop_pkg::ARM_NONE;
      for (int i = 0; i < 3; i++) tok[i] <= 8'h00;
      for (int i = 0; i < loop_pkg::REG_FILE_SIZE; i++) begin
        ctrl[i] <= loop_pkg::REG_RESET;
      end
    end else begin
      if (lad_own) SYNTAX_ERROR <= 1'b0;
      if (got_sda && TALKER) armed <= loop_pkg::ARM_NONE;
      if (data_take && (is_sep || is_lf)) begin
        tok_len <= 2'd0;
        tok_over <= 1'b0;
      end else if (data_take && tok_len == 2'd3) begin
        tok_over <= 1'b1;
      end else if (data_take) begin
        tok[tok_len] <= ch;
        tok_len <= tok_len + 2'd1;
      end
      if (exec && !known) SYNTAX_ERROR <= 1'b1;
      if (exec && i_sp)
        ctrl[loop_pkg::REG_FRAME][loop_pkg::FRAME_PARITY_BIT] <= d3[0];
      if (exec && i_ss)
        ctrl[loop_pkg::REG_FRAME][loop_pkg::FRAME_STOP_BIT] <= d3[0];
      if (exec && i_sw) begin
        ctrl[loop_pkg::REG_FRAME][loop_pkg::FRAME_WORD_LSB +: 2]
            <= d3[1:0];
      end
      if (exec && i_sr0) armed <= loop_pkg::ARM_CONTROL;
      if (exec && i_sr2) armed <= loop_pkg::ARM_CHARACTER;
      if (exec && i_sl0) ctrl[loop_pkg::REG_HANDSHAKE][2:0] <= 3'h0;
      if (exec && i_sb) ctrl[loop_pkg::REG_RATE] <= hexv[3:0];
      if (exec && i_p) ctrl[loop_pkg::REG_PARITY][3:1] <= d2[2:0];
      if (exec && i_c0) ctrl[loop_pkg::REG_PROTOCOL] <= 4'h0;
      if (exec && i_c2) begin
        ctrl[loop_pkg::REG_PROTOCOL][loop_pkg::PROTO_RECEIVER_BIT]
            <= 1'b1;
      end
      if (exec && i_se && d3 == 8'h00) begin
        ctrl[loop_pkg::REG_SRQ_MASTER] <= 4'h0;
        ctrl[loop_pkg::REG_BUF_REQ] <= 4'h0;
        ctrl[loop_pkg::REG_EVENT_REQ] <= 4'h0;
      end else if (exec && i_se) begin
        ctrl[loop_pkg::REG_SRQ_MASTER][loop_pkg::SRQ_ALL_BIT] <= 1'b1;
        if (d3 == 8'h06) begin
          ctrl[loop_pkg::REG_SRQ_MASTER][loop_pkg::SRQ_DATA_ERR_BIT]
              <= 1'b1;
        end else begin
          ctrl[loop_pkg::REG_BUF_REQ][2'(d3 - 8'h01)] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // readback transmitter
  always_ff @(posedge CLK) begin
    if (RST) begin
      tx_state <= loop_pkg::TX_IDLE;
      sending <= loop_pkg::ARM_NONE;
      idx <= 4'h0;
      LINK.rsp_valid <= 1'b0;
      LINK.rsp_eot <= 1'b0;
      LINK.rsp_data <= 8'h00;
    end else begin
      LINK.rsp_valid <= 1'b0;
      LINK.rsp_eot <= 1'b0;
      case (tx_state)
        loop_pkg::TX_IDLE: begin
          if (got_sda && TALKER) begin
            sending <= armed;
            idx <= 4'h0;
            tx_state <= armed == loop_pkg::ARM_NONE
                ? loop_pkg::TX_EOT : loop_pkg::TX_BYTES;
          end
        end
        loop_pkg::TX_BYTES: begin
          LINK.rsp_valid <= 1'b1;
          LINK.rsp_data <= {loop_pkg::READBACK_HIGH, rb_nib};
          idx <= idx + 4'h1;
          if (idx == rb_last) tx_state <= loop_pkg::TX_EOT;
        end
        loop_pkg::TX_EOT: begin
          LINK.rsp_valid <= 1'b1;
          LINK.rsp_eot <= 1'b1;
          LINK.rsp_data <= 8'h00;
          tx_state <= loop_pkg::TX_IDLE;
        end
        default: tx_state <= loop_pkg::TX_IDLE;
      endcase
      if (got_unt && tx_state != loop_pkg::TX_IDLE)
        tx_state <= loop_pkg::TX_IDLE;
    end
  end

  // ==========================================================
  // outputs steered by the register file
  always_ff @(posedge CLK) begin
    if (RST) begin
      SERVICE_REQUEST <= 1'b0;
      AUTODISCONNECT <= 1'b0;
      WORD_CODE <= 2'b00;
      TWO_STOP <= 1'b0;
      PARITY_REPORT <= 1'b0;
      RECEIVER_PROTOCOL <= 1'b0;
      HANDSHAKE_IGNORE <= 3'b000;
    end else begin
      SERVICE_REQUEST <= ctrl[loop_pkg::REG_SRQ_MASTER][loop_pkg::SRQ_ALL_BIT]
          && srq_any;
      AUTODISCONNECT <= ctrl[loop_pkg::REG_DISCONNECT][loop_pkg::DISC_DSR_BIT]
          && !DSR;
      WORD_CODE <= ctrl[loop_pkg::REG_FRAME][loop_pkg::FRAME_WORD_LSB +: 2];
      TWO_STOP <= ctrl[loop_pkg::REG_FRAME][loop_pkg::FRAME_STOP_BIT];
      PARITY_REPORT <= ctrl[loop_pkg::REG_FRAME][loop_pkg::FRAME_PARITY_BIT];
      RECEIVER_PROTOCOL
          <= ctrl[loop_pkg::REG_PROTOCOL][loop_pkg::PROTO_RECEIVER_BIT];
      HANDSHAKE_IGNORE <= ctrl[loop_pkg::REG_HANDSHAKE][2:0];
    end
  end
endmodule : loop_device

// ### core/loop_link_if.sv
// Purpose: message link between loop controller and device
// Assumes: both ends on CLK; every valid is taken at the edge it is seen
// Notes: no back-pressure, one message per cycle at most
interface loop_link_if;
  logic msg_valid;
  loop_pkg::msg_kind_type msg_kind;
  logic [7:0] msg_data;
  logic rsp_valid;
  logic rsp_eot;
  logic [7:0] rsp_data;

  modport device (
    input msg_valid,
    input msg_kind,
    input msg_data,
    output rsp_valid,
    output rsp_eot,
    output rsp_data
  );

  modport controller (
    output msg_valid,
    output msg_kind,
    output msg_data,
    input rsp_valid,
    input rsp_eot,
    input rsp_data
  );
endinterface : loop_link_if

// ### core/loop_pkg.sv
// Purpose: shared constants and types for the loop instruction interpreter
// Assumes: one clock, synchronous active-high reset
// Notes: register indices are nibble registers inside the device
package loop_pkg;
  // ==========================================================
  // link message kinds
  typedef enum logic [2:0] {
    MSG_DATA = 3'b000,
    MSG_REN = 3'b001,
    MSG_NRE = 3'b010,
    MSG_LAD = 3'b011,
    MSG_UNL = 3'b100,
    MSG_TAD = 3'b101,
    MSG_UNT = 3'b110,
    MSG_SDA = 3'b111
  } msg_kind_type;

  typedef enum logic [1:0] {
    ARM_NONE = 2'b00,
    ARM_CONTROL = 2'b01,
    ARM_CHARACTER = 2'b10
  } arm_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_BYTES = 2'b01,
    TX_EOT = 2'b10
  } tx_state_type;

  // ==========================================================
  // device register file
  localparam int REG_FILE_SIZE = 16;
  localparam int CTRL_COUNT = 14;
  localparam int CHAR_COUNT = 12;
  localparam logic [3:0] REG_RESET = 4'h0;
  localparam logic [3:0] REG_SRQ_MASTER = 4'h0;
  localparam logic [3:0] REG_BUF_REQ = 4'h1;
  localparam logic [3:0] REG_EVENT_REQ = 4'h2;
  localparam logic [3:0] REG_FRAME = 4'h6;
  localparam logic [3:0] REG_RATE = 4'h7;
  localparam logic [3:0] REG_PARITY = 4'h8;
  localparam logic [3:0] REG_HANDSHAKE = 4'h9;
  localparam logic [3:0] REG_PROTOCOL = 4'hB;
  localparam logic [3:0] REG_DISCONNECT = 4'hD;
  localparam int FRAME_PARITY_BIT = 0;
  localparam int FRAME_WORD_LSB = 1;
  localparam int FRAME_STOP_BIT = 3;
  localparam int SRQ_ALL_BIT = 3;
  localparam int SRQ_DATA_ERR_BIT = 2;
  localparam int DISC_DSR_BIT = 2;
  localparam int PROTO_RECEIVER_BIT = 3;
  localparam logic [3:0] READBACK_HIGH = 4'h3;
  localparam logic [4:0] OWN_ADDR_DEFAULT = 5'h03;

  // ==========================================================
  // instruction characters
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_HEX_OFS = 8'h37;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_L = 8'h4C;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_W = 8'h57;

  // ==========================================================
  // controller APB map
  localparam logic [7:0] OFS_MESSAGE = 8'h00;
  localparam logic [7:0] OFS_RX = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam int IRQ_BYTE = 0;
  localparam int IRQ_EOT = 1;
  localparam int IRQ_WIDTH = 2;
endpackage : loop_pkg

// ### tb/loop_properties.sv
// ==========================================================
// Purpose: link-level properties of the readback exchange
// Assumes: both ends on CLK, RST synchronous active high
// Notes: talker state is rebuilt here from addressing messages
module loop_properties #(
  parameter logic [4:0] OWN_ADDR = loop_pkg::OWN_ADDR_DEFAULT
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic msg_valid,
  input var loop_pkg::msg_kind_type msg_kind,
  input wire logic [7:0] msg_data,
  input wire logic rsp_valid,
  input wire logic rsp_eot,
  input wire logic [7:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic talker_h;
  logic [4:0] cnt;
  wire tad = msg_valid && msg_kind == loop_pkg::MSG_TAD;
  wire sda = msg_valid && msg_kind == loop_pkg::MSG_SDA;
  wire unt = msg_valid && msg_kind == loop_pkg::MSG_UNT;
  always_ff @(posedge CLK) begin
    if (RST) talker_h <= 1'b0;
    else if (tad) talker_h <= msg_data[4:0] == OWN_ADDR;
    else if (unt) talker_h <= 1'b0;
  end
  // counts readback bytes of the current burst, the end marker resets it
  always_ff @(posedge CLK) begin
    if (RST || (rsp_valid && rsp_eot)) cnt <= 5'h00;
    else if (rsp_valid) cnt <= cnt + 5'h01;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_byte_high_nibble: assert property (
    rsp_valid && !rsp_eot |-> rsp_data[7:4] == loop_pkg::READBACK_HIGH)
    else $error("readback byte high nibble wrong");
  a_eot_data_zero: assert property (
    rsp_valid && rsp_eot |-> rsp_data == 8'h00)
    else $error("end marker carries data");
  a_eot_with_valid: assert property (rsp_eot |-> rsp_valid)
    else $error("end marker without valid");
  a_quiet_after_eot: assert property (
    rsp_valid && rsp_eot |=> !rsp_valid [*2])
    else $error("response after end marker");
  a_sda_answers: assert property (
    sda && talker_h |-> ##[1:2] rsp_valid)
    else $error("send-data not answered");
  a_burst_contiguous: assert property (
    rsp_valid && !rsp_eot && !unt |=> rsp_valid)
    else $error("gap inside readback burst");
  a_burst_count: assert property (
    rsp_valid && rsp_eot |-> cnt == 5'h0E || cnt == 5'h0C || cnt == 5'h00)
    else $error("readback byte count wrong");
  a_talker_only: assert property (rsp_valid |-> talker_h)
    else $error("response while not talker");
endmodule : loop_properties

// ### tb/remote_instruction_interpreter_tb.sv
// ==========================================================
// Purpose: end-to-end bench of loop controller and loop device
// Assumes: APB master on CLK, 8 ns period, reset held 2 cycles
// Notes: readback bytes are captured by a link monitor
module remote_instruction_interpreter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic tx_empty, tx_not_full, rx_not_empty, rx_full, data_error, dsr;
  logic remote, listener, talker, syntax_error, service_request;
  logic autodisconnect, two_stop, parity_report, receiver_protocol;
  logic [1:0] word_code;
  logic [2:0] handshake_ignore;
  int err_total = 0;
  int samples_checked = 0;
  int n_eot;
  logic [3:0] exp_nib;
  logic [7:0] rq[$];
  logic [3:0] ctrl_exp[14] = '{4'hC, 4'h6, 4'h0, 4'h0, 4'h0, 4'h0, 4'hF,
    4'h3, 4'h2, 4'h0, 4'h0, 4'h8, 4'h0, 4'h0};
  loop_link_if link ();
  loop_controller loop_controller_i (.CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
    .LINK(link));
  loop_device loop_device_i (.CLK(clk), .RST(rst), .LINK(link),
    .TX_EMPTY(tx_empty), .TX_NOT_FULL(tx_not_full),
    .RX_NOT_EMPTY(rx_not_empty), .RX_FULL(rx_full),
    .DATA_ERROR(data_error), .DSR(dsr), .REMOTE(remote),
    .LISTENER(listener), .TALKER(talker), .SYNTAX_ERROR(syntax_error),
    .SERVICE_REQUEST(service_request), .AUTODISCONNECT(autodisconnect),
    .WORD_CODE(word_code), .TWO_STOP(two_stop),
    .PARITY_REPORT(parity_report), .RECEIVER_PROTOCOL(receiver_protocol),
    .HANDSHAKE_IGNORE(handshake_ignore));
  loop_properties loop_properties_i (.CLK(clk), .RST(rst),
    .msg_valid(link.msg_valid), .msg_kind(link.msg_kind),
    .msg_data(link.msg_data), .rsp_valid(link.rsp_valid),
    .rsp_eot(link.rsp_eot), .rsp_data(link.rsp_data));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (link.rsp_valid === 1'b1) begin
      if (link.rsp_eot === 1'b1) n_eot++;
      else rq.push_back(link.rsp_data);
    end
  end

  // ==========================================================
  // shared tasks
  task stop_test;
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task msg(input loop_pkg::msg_kind_type k, input logic [7:0] d);
    apb(1'b1, loop_pkg::OFS_MESSAGE, {21'h0, k, d});
    tick(3);
  endtask : msg

  task send_line(input string s);
    foreach (s[i]) msg(loop_pkg::MSG_DATA, s[i]);
    msg(loop_pkg::MSG_DATA, loop_pkg::CH_CR);
    msg(loop_pkg::MSG_DATA, loop_pkg::CH_LF);
  endtask : send_line

  // ==========================================================
  // scenarios
  task s_remote;
    msg(loop_pkg::MSG_UNL, 8'h00);
    msg(loop_pkg::MSG_REN, 8'h00);
    msg(loop_pkg::MSG_LAD, 8'h03);
    chk(32'({remote, listener}), 32'h3);
  endtask : s_remote

  task s_format;
    send_line("SB3;SW0;P1;SS0");
    chk(32'({two_stop, word_code}), 32'h0);
    send_line("C0;C2;SL0");
    chk(32'({receiver_protocol, handshake_ignore}), 32'h8);
    for (int w = 0; w < 4; w++) begin
      send_line($sformatf("SW%0d", w));
      chk(32'(word_code), 32'(w));
    end
    send_line("SP1;SS1");
    chk(32'({two_stop, parity_report}), 32'h3);
    chk(32'(syntax_error), 32'h0);
  endtask : s_format

  task s_service;
    tx_empty <= 1'b1;
    send_line("SE1");
    chk(32'(service_request), 32'h1);
    send_line("SE0;XQ");
    chk(32'({syntax_error, service_request}), 32'h2);
    tx_empty <= 1'b0;
    send_line("SE6;SE2;SE3");
    tx_not_full <= 1'b1;
    tick(3);
    chk(32'(service_request), 32'h1);
    tx_not_full <= 1'b0;
    data_error <= 1'b1;
    tick(3);
    chk(32'(service_request), 32'h1);
    data_error <= 1'b0;
    tx_empty <= 1'b1;
    dsr <= 1'b0;
    tick(3);
    chk(32'(service_request), 32'h0);
    chk(32'(autodisconnect), 32'h0);
  endtask : s_service

  task s_readback(input string ins, input int n);
    msg(loop_pkg::MSG_LAD, 8'h03);
    send_line(ins);
    msg(loop_pkg::MSG_TAD, 8'h03);
    chk(32'({talker, listener}), 32'h2);
    rq.delete();
    n_eot = 0;
    msg(loop_pkg::MSG_SDA, 8'h00);
    tick(n + 4);
    chk(32'(rq.size()), 32'(n));
    foreach (rq[i]) begin
      exp_nib = ins == "SR0" ? ctrl_exp[i] : 4'h0;
      chk(32'(rq[i]), {24'h0, 4'h3, exp_nib});
    end
    chk(32'(n_eot), 32'h1);
    msg(loop_pkg::MSG_UNT, 8'h00);
    chk(32'(talker), 32'h0);
  endtask : s_readback

  // byte-received stays masked, so clearing the end flag drops the line
  task s_irq;
    apb(1'b0, loop_pkg::OFS_IRQ_STATUS, 32'h0);
    chk(rd, 32'h3);
    chk(32'(irq), 32'h1);
    apb(1'b1, loop_pkg::OFS_IRQ_STATUS, 32'h2);
    tick(2);
    chk(32'(irq), 32'h0);
    apb(1'b0, loop_pkg::OFS_IRQ_STATUS, 32'h0);
    chk(rd, 32'h1);
  endtask : s_irq

  task s_refuse;
    msg(loop_pkg::MSG_UNL, 8'h00);
    chk(32'(listener), 32'h0);
    send_line("SW1");
    chk(32'(word_code), 32'h3);
    msg(loop_pkg::MSG_NRE, 8'h00);
    chk(32'(remote), 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
  endtask : s_refuse

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tx_empty = 1'b0;
    tx_not_full = 1'b0;
    rx_not_empty = 1'b0;
    rx_full = 1'b0;
    data_error = 1'b0;
    dsr = 1'b1;
    tick(2);
    rst <= 1'b0;
    s_remote();
    s_format();
    s_service();
    apb(1'b1, loop_pkg::OFS_IRQ_MASK, 32'h2);
    s_readback("SR0", 14);
    s_irq();
    s_readback("SR2", 12);
    s_refuse();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule : remote_instruction_interpreter_tb
